// file: src/swid_master.sv
// Purpose: Master controller that reads or searches a 64-bit single-wire ID ROM.
// Assumes: Open-drain line with external pull-up; lineIn synchronous to sysClk.
// Notes: The CRC check runs over all 64 bits and expects zero.
`timescale 1ns/100ps
module swid_master (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic startRead,
  input wire logic startSearch,
  input wire logic [63:0] searchPath,
  output logic busy,
  output logic done,
  output logic presence,
  output logic crcOk,
  output logic searchFail,
  output logic [63:0] romData,
  output logic [11:0] customerId,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOeN
);
  import swid_pkg::*;
  typedef enum logic [3:0] {
    M_IDLE, M_RESET, M_CMD, M_READ, M_SRCH_BIT, M_SRCH_CMP, M_SRCH_WR, M_WAIT, M_END
  } swid_m_e;
  typedef struct packed {
    logic [1:0] rstSync;
    swid_m_e state;
    swid_m_e after;
    logic search;
    logic [7:0] cmd;
    logic [6:0] idx;
    logic trueBit;
    logic [63:0] rom;
    logic pres;
    logic crcGood;
    logic fail;
    logic done;
    logic opStart;
    swid_op_e opKind;
    logic opBit;
  } swid_m_s;
  swid_m_s st_reg;
  swid_m_s st_next;
  logic rstLocalN;
  logic opDone;
  logic opResult;
  logic [7:0] crcValue;
  logic crcEn;
  logic crcClear;
  assign rstLocalN = st_reg.rstSync[1];

  // The last bit is folded in here, since the running value lags by one bit.
  function automatic logic crcZero(input logic [7:0] c, input logic b);
    logic [7:0] n;
    n = (c >> 1) ^ ((c[0] ^ b) ? CrcPoly : 8'h00);
    crcZero = (n == 8'h00);
  endfunction : crcZero

  always_comb begin
    st_next = st_reg;
    st_next.rstSync = {st_reg.rstSync[0], 1'b1};
    st_next.opStart = 1'b0;
    st_next.done = 1'b0;
    crcEn = 1'b0;
    crcClear = 1'b0;
    unique case (st_reg.state)
      M_IDLE: begin
        if (startRead || startSearch) begin
          st_next.search = startSearch && !startRead;
          st_next.cmd = (startSearch && !startRead) ? CmdSearchRom : CmdReadRom;
          st_next.idx = '0;
          st_next.fail = 1'b0;
          st_next.crcGood = 1'b0;
          st_next.opStart = 1'b1;
          st_next.opKind = SWID_OP_RESET;
          st_next.state = M_RESET;
          crcClear = 1'b1;
        end
      end
      M_RESET: begin
        if (opDone) begin
          st_next.pres = opResult;
          if (!opResult) begin
            st_next.state = M_END;
          end else begin
            st_next.opStart = 1'b1;
            st_next.opKind = SWID_OP_WRITE;
            st_next.opBit = st_reg.cmd[0];
            st_next.state = M_CMD;
          end
        end
      end
      M_CMD: begin
        if (opDone) begin
          st_next.idx = st_reg.idx + 7'd1;
          st_next.opStart = 1'b1;
          if (st_reg.idx == 7'd7) begin
            st_next.idx = '0;
            st_next.opKind = SWID_OP_READ;
            st_next.state = st_reg.search ? M_SRCH_BIT : M_READ;
          end else begin
            st_next.opKind = SWID_OP_WRITE;
            st_next.opBit = st_reg.cmd[st_reg.idx[2:0] + 3'd1];
          end
        end
      end
      M_READ: begin
        if (opDone) begin
          st_next.rom[st_reg.idx[5:0]] = opResult;
          crcEn = 1'b1;
          if (st_reg.idx == 7'd63) begin
            st_next.crcGood = crcZero(crcValue, opResult);
            st_next.state = M_END;
          end else begin
            st_next.idx = st_reg.idx + 7'd1;
            st_next.opStart = 1'b1;
            st_next.opKind = SWID_OP_READ;
          end
        end
      end
      M_SRCH_BIT: begin
        if (opDone) begin
          st_next.trueBit = opResult;
          st_next.opStart = 1'b1;
          st_next.opKind = SWID_OP_READ;
          st_next.state = M_SRCH_CMP;
        end
      end
      M_SRCH_CMP: begin
        if (opDone) begin
          st_next.opStart = 1'b1;
          st_next.opKind = SWID_OP_WRITE;
          st_next.state = M_SRCH_WR;
          if (st_reg.trueBit && opResult) begin
            st_next.fail = 1'b1;
            st_next.opStart = 1'b0;
            st_next.state = M_END;
          end else if (st_reg.trueBit != opResult) begin
            st_next.opBit = st_reg.trueBit;
          end else begin
            st_next.opBit = searchPath[st_reg.idx[5:0]];
          end
        end
      end
      M_SRCH_WR: begin
        if (opDone) begin
          st_next.rom[st_reg.idx[5:0]] = st_reg.opBit;
          crcEn = 1'b1;
          if (st_reg.idx == 7'd63) begin
            st_next.crcGood = crcZero(crcValue, st_reg.opBit);
            st_next.state = M_END;
          end else begin
            st_next.idx = st_reg.idx + 7'd1;
            st_next.opStart = 1'b1;
            st_next.opKind = SWID_OP_READ;
            st_next.state = M_SRCH_BIT;
          end
        end
      end
      M_WAIT: st_next.state = M_END;
      M_END: begin
        st_next.done = 1'b1;
        st_next.state = M_IDLE;
      end
      default: st_next.state = M_IDLE;
    endcase
  end

  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  swid_crc8 u_crc (
    .sysClk(sysClk),
    .rstLocalN(rstLocalN),
    .crcClear(crcClear),
    .crcEn(crcEn),
    .crcBit(st_reg.state == M_READ ? opResult : st_reg.opBit),
    .crcValue(crcValue)
  );

  swid_slot u_slot (
    .sysClk(sysClk),
    .rstLocalN(rstLocalN),
    .opStart(st_reg.opStart),
    .opKind(st_reg.opKind),
    .opBit(st_reg.opBit),
    .opDone(opDone),
    .opResult(opResult),
    .lineIn(lineIn),
    .lineOut(lineOut),
    .lineOeN(lineOeN)
  );

  assign busy = (st_reg.state != M_IDLE);
  assign done = st_reg.done;
  assign presence = st_reg.pres;
  assign crcOk = st_reg.crcGood;
  assign searchFail = st_reg.fail;
  assign romData = st_reg.rom;
  assign customerId = st_reg.rom[55:44];
endmodule : swid_master

// file: src/swid_pkg.sv
// Purpose: Shared constants for the single-wire identification ROM master.
// Assumes: 100 MHz system clock.
// Notes: Times are in microseconds; cycle counts derive from them.
package swid_pkg;
  localparam int ClkMhz = 100;
  localparam int ResetLowUs = 480;
  localparam int ResetHighUs = 480;
  localparam int PresenceWaitMinUs = 15;
  localparam int PresenceSampleUs = 70;
  localparam int SlotLengthUs = 70;
  localparam int WriteOneLowUs = 6;
  localparam int WriteZeroLowUs = 65;
  localparam int ReadLowUs = 2;
  localparam int ReadSampleUs = 12;
  localparam int RecoveryGapUs = 2;
  localparam int ResetLowCyc = ResetLowUs * ClkMhz;
  localparam int ResetHighCyc = ResetHighUs * ClkMhz;
  localparam int PresenceSampleCyc = PresenceSampleUs * ClkMhz;
  localparam int SlotLengthCyc = SlotLengthUs * ClkMhz;
  localparam int WriteOneLowCyc = WriteOneLowUs * ClkMhz;
  localparam int WriteZeroLowCyc = WriteZeroLowUs * ClkMhz;
  localparam int ReadLowCyc = ReadLowUs * ClkMhz;
  localparam int ReadSampleCyc = ReadSampleUs * ClkMhz;
  localparam int RecoveryGapCyc = RecoveryGapUs * ClkMhz;
  localparam logic [7:0] CmdReadRom = 8'h33;
  localparam logic [7:0] CmdSearchRom = 8'hf0;
  localparam logic [7:0] CrcPoly = 8'h8c;
  localparam logic [15:0] ResetCountInit = 16'h0000;
  typedef enum logic [1:0] {SWID_OP_RESET, SWID_OP_WRITE, SWID_OP_READ} swid_op_e;
endpackage : swid_pkg

// file: src/swid_crc8.sv
// Purpose: Running CRC-8 over received ROM bits, least significant bit first.
// Assumes: One bit per clear-free enable pulse.
// Notes: Reflected form of x^8 + x^5 + x^4 + 1.
`timescale 1ns/100ps
module swid_crc8 (
  input wire logic sysClk,
  input wire logic rstLocalN,
  input wire logic crcClear,
  input wire logic crcEn,
  input wire logic crcBit,
  output logic [7:0] crcValue
);
  import swid_pkg::*;
  typedef struct packed {logic [7:0] crc;} swid_crc_s;
  swid_crc_s st_reg;
  swid_crc_s st_next;
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crcStep = (c >> 1) ^ (fb ? CrcPoly : 8'h00);
  endfunction : crcStep
  always_comb begin
    st_next = st_reg;
    if (crcClear) begin
      st_next.crc = 8'h00;
    end else if (crcEn) begin
      st_next.crc = crcStep(st_reg.crc, crcBit);
    end
  end
  always_ff @(posedge sysClk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign crcValue = st_reg.crc;
endmodule : swid_crc8

// file: src/swid_slot.sv
// Purpose: Timed single-wire primitives: reset/presence, write slot, read slot.
// Assumes: Pull-up on the line; line input synchronous to sysClk.
// Notes: Output enable is low while the pin is driven low.
`timescale 1ns/100ps
module swid_slot (
  input wire logic sysClk,
  input wire logic rstLocalN,
  input wire logic opStart,
  input wire swid_pkg::swid_op_e opKind,
  input wire logic opBit,
  output logic opDone,
  output logic opResult,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOeN
);
  import swid_pkg::*;
  typedef enum logic [2:0] {SL_IDLE, SL_LOW, SL_HIGH, SL_RECOVER, SL_DONE} swid_sl_e;
  typedef struct packed {
    swid_sl_e state;
    swid_op_e kind;
    logic bitVal;
    logic result;
    logic [19:0] count;
  } swid_slot_s;
  swid_slot_s st_reg;
  swid_slot_s st_next;
  function automatic logic [19:0] lowCycles(input swid_op_e k, input logic b);
    if (k == SWID_OP_RESET) begin
      lowCycles = 20'(ResetLowCyc);
    end else if (k == SWID_OP_READ) begin
      lowCycles = 20'(ReadLowCyc);
    end else begin
      lowCycles = b ? 20'(WriteOneLowCyc) : 20'(WriteZeroLowCyc);
    end
  endfunction : lowCycles
  always_comb begin
    st_next = st_reg;
    st_next.count = st_reg.count + 20'd1;
    unique case (st_reg.state)
      SL_IDLE: begin
        st_next.count = '0;
        if (opStart) begin
          st_next.state = SL_LOW;
          st_next.kind = opKind;
          st_next.bitVal = opBit;
          st_next.result = 1'b0;
        end
      end
      SL_LOW: begin
        if (st_reg.count == lowCycles(st_reg.kind, st_reg.bitVal) - 20'd1) begin
          st_next.state = SL_HIGH;
        end
      end
      SL_HIGH: begin
        if (st_reg.kind == SWID_OP_READ && st_reg.count == 20'(ReadSampleCyc)) begin
          st_next.result = lineIn;
        end
        if (st_reg.kind == SWID_OP_RESET && st_reg.count == 20'(ResetLowCyc + PresenceSampleCyc)) begin
          st_next.result = !lineIn;
        end
        if (st_reg.kind == SWID_OP_RESET) begin
          if (st_reg.count == 20'(ResetLowCyc + ResetHighCyc - 1)) begin
            st_next.state = SL_DONE;
          end
        end else if (st_reg.count >= 20'(SlotLengthCyc - 1)) begin
          st_next.state = SL_RECOVER;
          st_next.count = '0;
        end
      end
      SL_RECOVER: begin
        if (!lineIn) begin
          st_next.count = '0;
        end else if (st_reg.count == 20'(RecoveryGapCyc - 1)) begin
          st_next.state = SL_DONE;
        end
      end
      SL_DONE: begin
        st_next.state = SL_IDLE;
      end
      default: st_next.state = SL_IDLE;
    endcase
  end
  always_ff @(posedge sysClk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign lineOut = 1'b0;
  assign lineOeN = (st_reg.state != SL_LOW);
  assign opDone = (st_reg.state == SL_DONE);
  assign opResult = st_reg.result;
endmodule : swid_slot

// file: dv/swid_master_asserts.sv
// Purpose: Port-level timing checks for the single-wire ROM master.
// Assumes: 100 MHz sysClk, so 100 cycles make one microsecond.
// Notes: Counters saturate; relCnt, hiCnt and gapCnt start full and lowCnt at zero, so the first slot after reset passes.
`timescale 1ns/100ps
module swid_master_asserts (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic startRead,
  input wire logic startSearch,
  input wire logic [63:0] searchPath,
  input wire logic busy,
  input wire logic done,
  input wire logic presence,
  input wire logic crcOk,
  input wire logic searchFail,
  input wire logic [63:0] romData,
  input wire logic [11:0] customerId,
  input wire logic lineIn,
  input wire logic lineOut,
  input wire logic lineOeN
);
  logic [19:0] lowCnt, relCnt, hiCnt, gapCnt;
  logic lastLong;
  function automatic logic [19:0] inc(input logic [19:0] v);
    return (v == 20'hfffff) ? v : v + 20'h1;
  endfunction : inc
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      lowCnt <= 20'h0;
      relCnt <= 20'hfffff;
      hiCnt <= 20'hfffff;
      gapCnt <= 20'hfffff;
      lastLong <= 1'b0;
    end else begin
      lowCnt <= lineOeN ? 20'h0 : inc(lowCnt);
      relCnt <= lineOeN ? inc(relCnt) : 20'h0;
      hiCnt <= lineIn ? inc(hiCnt) : 20'h0;
      gapCnt <= $fell(lineOeN) ? 20'h1 : inc(gapCnt);
      lastLong <= $rose(lineOeN) ? (lowCnt >= 20'hbb80) : lastLong;
    end
  end
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!rstn);
  drive_level_a: assert property (lineOut == 1'b0) else $error("line driven high");
  id_field_a: assert property (customerId == romData[55:44])
    else $error("customer id differs");
  start_take_a: assert property (!busy && (startRead || startSearch) |=> busy)
    else $error("start not taken");
  done_pulse_a: assert property (done |=> !done) else $error("done too long");
  idle_release_a: assert property (!busy |-> lineOeN) else $error("line held idle");
  low_width_a: assert property ($rose(lineOeN) |-> (lowCnt inside
    {[20'h64:20'h5db], [20'h1771:20'h2edf], [20'hbb80:20'h176ff]})) else $error("bad low width");
  recovery_gap_a: assert property ($fell(lineOeN) |-> hiCnt >= 20'h64)
    else $error("recovery too short");
  reset_release_a: assert property ($fell(lineOeN) && lastLong |-> relCnt >= 20'hbb80)
    else $error("reset high time short");
  slot_period_a: assert property ($fell(lineOeN) |-> gapCnt >= 20'h1770)
    else $error("slot too short");
  cover property (done && presence && crcOk);
  cover property (done && !presence);
  cover property ($rose(lineOeN) && lowCnt >= 20'hbb80);
endmodule : swid_master_asserts

bind swid_master swid_master_asserts u_chk (.sysClk(sysClk), .rstn(rstn),
  .startRead(startRead), .startSearch(startSearch), .searchPath(searchPath), .busy(busy),
  .done(done), .presence(presence), .crcOk(crcOk), .searchFail(searchFail),
  .romData(romData), .customerId(customerId), .lineIn(lineIn), .lineOut(lineOut),
  .lineOeN(lineOeN));

// file: dv/swid_rom_model.sv
// Purpose: Behavioural identification ROM on the shared line.
// Assumes: Line pulled up; a reset is any low of at least 480 us.
// Notes: Search is not answered; an offset of 3 ns keeps edges off sysClk.
`timescale 1ns/100ps
module swid_rom_model (
  input wire logic line,
  input wire logic enable,
  input wire logic [63:0] rom,
  output logic pullLow
);
  realtime t0;
  logic [7:0] cmd;
  int nBits;
  int state;
  initial begin
    pullLow = 1'b0;
    state = 0;
    nBits = 0;
    cmd = 8'h00;
    forever begin
      @(negedge line);
      t0 = $realtime;
      #3;
      if (state == 2 && rom[nBits] == 1'b0) pullLow = 1'b1;
      #30000;
      if (state == 1) begin
        cmd = {line, cmd[7:1]};
        nBits++;
      end
      pullLow = 1'b0;
      if (state == 2) begin
        nBits++;
        if (nBits == 64) state = 0;
      end
      if (state == 1 && nBits == 8) begin
        state = (cmd == 8'h33 || cmd == 8'h0f) ? 2 : 0;
        nBits = 0;
      end
      #1;
      if (line == 1'b0) begin
        @(posedge line);
        if ($realtime - t0 >= 480000 && enable) begin
          #30000 pullLow = 1'b1;
          #120000 pullLow = 1'b0;
          state = 1;
          nBits = 0;
        end
      end
    end
  end
endmodule : swid_rom_model

// file: dv/tb_swid_master.sv
// Purpose: Self-checking bench for the single-wire ROM master.
// Assumes: One ROM model on the line with a pull-up.
// Notes: Each read transaction with a device present takes about 615000 cycles.
`timescale 1ns/100ps
module tb_swid_master;
  import swid_pkg::*;
  logic sysClk = 1'b0;
  logic rstn = 1'b0;
  logic startRead = 1'b0;
  logic startSearch = 1'b0;
  logic devOn = 1'b0;
  logic [63:0] devRom = 64'h0;
  logic busy, done, presence, crcOk, searchFail, lineIn, lineOut, lineOeN, devPull;
  logic [63:0] romData;
  logic [11:0] customerId;
  int miscompares = 0;
  int numChecks = 0;
  int cycles = 0;
  // Family byte and serial number values are arbitrary.
  localparam logic [55:0] RomBody = 56'h7a3_c0ffe1234_5a;
  always #5 sysClk = ~sysClk;
  assign lineIn = (lineOeN ? 1'b1 : lineOut) & ~devPull;
  swid_master DUT (.sysClk(sysClk), .rstn(rstn), .startRead(startRead),
    .startSearch(startSearch), .searchPath(64'h0), .busy(busy), .done(done),
    .presence(presence), .crcOk(crcOk), .searchFail(searchFail), .romData(romData),
    .customerId(customerId), .lineIn(lineIn), .lineOut(lineOut), .lineOeN(lineOeN));
  swid_rom_model u_rom (.line(lineIn), .enable(devOn), .rom(devRom), .pullLow(devPull));
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? CrcPoly : 8'h00);
    return c;
  endfunction : crc8
  task automatic err(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask : err
  task automatic chk1(input logic got, input logic exp, input string m);
    numChecks++;
    if (got !== exp) err(m);
  endtask : chk1
  task automatic chk64(input logic [63:0] got, input logic [63:0] exp, input string m);
    numChecks++;
    if (got !== exp) err(m);
  endtask : chk64
  task automatic run_op(input logic rd, input logic sr);
    int n;
    n = 0;
    @(posedge sysClk);
    #1;
    startRead = rd;
    startSearch = sr;
    @(posedge sysClk);
    #1;
    startRead = 1'b0;
    startSearch = 1'b0;
    while (done !== 1'b1 && n < 700000) begin
      @(posedge sysClk);
      #1;
      n++;
      startRead = (n == 20);
    end
    if (done !== 1'b1) err("no done");
  endtask : run_op
  task automatic test_no_presence();
    devOn = 1'b0;
    run_op(1'b1, 1'b0);
    chk1(presence, 1'b0, "presence seen");
    repeat (5) @(posedge sysClk);
    chk1(busy, 1'b0, "start taken while busy");
    $display("test_no_presence finished");
  endtask : test_no_presence
  task automatic test_read_good();
    devRom = {crc8(RomBody), RomBody};
    devOn = 1'b1;
    run_op(1'b1, 1'b1);
    chk1(presence, 1'b1, "no presence");
    chk64(romData, devRom, "rom data");
    chk1(crcOk, 1'b1, "crc rejected");
    chk64({52'h0, customerId}, {52'h0, devRom[55:44]}, "customer id");
    chk1(searchFail, 1'b0, "search flag");
    $display("test_read_good finished");
  endtask : test_read_good
  task automatic test_read_badcrc();
    devRom = {~crc8(RomBody), RomBody};
    run_op(1'b1, 1'b0);
    chk64(romData, devRom, "rom data");
    chk1(crcOk, 1'b0, "crc accepted");
    $display("test_read_badcrc finished");
  endtask : test_read_badcrc
  task automatic test_search_nodev();
    devOn = 1'b1;
    run_op(1'b0, 1'b1);
    chk1(presence, 1'b1, "no presence in search");
    chk1(searchFail, 1'b1, "search fail missed");
    $display("test_search_nodev finished");
  endtask : test_search_nodev
  task automatic summarize();
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 2000000) begin
      err("timeout");
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge sysClk);
    #1;
    rstn = 1'b1;
    repeat (5) @(posedge sysClk);
    test_no_presence();
    test_read_good();
    test_read_badcrc();
    test_search_nodev();
    summarize();
  end
endmodule : tb_swid_master
